/* File: jtag_tap_controller_test.sv */
// Testbench: debugger end and device end joined over the TAP wires
`timescale 1ns/1ps
module jtag_tap_controller_test;
  import jtp_pkg::*;
  // Arbitrary identity value, bit 0 set as usual
  localparam logic [31:0] ID_VAL = 32'h0F0F_1235;
  logic clk, rst, porRst, jtag_enable_fuse, jtag_disable_bit;
  logic cmdValid, cmdIsIr, cmdReset, cmdReady, rspValid, scanUpdated, pullUpEn, portMode;
  logic [5:0] cmdLen, len;
  logic [31:0] cmdData, rspData, scanIn, scanOut, scanExp, expv, dat;
  logic [3:0] activeIns, code;
  integer fails, num_checks, seed, i, updCount, updBase;

  jtp_if tapIf();
  jtp_tap_device #(.ID_VALUE(ID_VAL)) jtp_tap_device_inst (.tap(tapIf.dev), .porRst(porRst),
    .jtag_enable_fuse(jtag_enable_fuse), .jtag_disable_bit(jtag_disable_bit), .clk(clk), .rst(rst),
    .scanIn(scanIn), .scanOut(scanOut), .scanUpdated(scanUpdated), .activeIns(activeIns),
    .pullUpEn(pullUpEn), .portMode(portMode));
  jtp_tap_host jtp_tap_host_inst (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdIsIr(cmdIsIr),
    .cmdReset(cmdReset), .cmdLen(cmdLen), .cmdData(cmdData), .cmdReady(cmdReady), .rspData(rspData),
    .rspValid(rspValid), .tap(tapIf.host));
  jtp_tap_checker jtp_tap_checker_inst (.tck(tapIf.tck), .tms(tapIf.tms), .tdi(tapIf.tdi),
    .tdo(tapIf.tdo), .tdoOe(tapIf.tdoOe), .porRst(porRst), .jtag_enable_fuse(jtag_enable_fuse),
    .jtag_disable_bit(jtag_disable_bit), .clk(clk), .rst(rst));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Bits expected out of the selected data register after a scan of n bits
  function automatic logic [31:0] expOut(input logic [3:0] c, input logic [31:0] d, input logic [31:0] p,
    input logic [5:0] n);
    logic [63:0] m;
    m = (64'h1 << n) - 64'h1;
    if (c == INS_IDCODE) expOut = ID_VAL & m[31:0];
    else if (c == INS_SCAN) expOut = p & m[31:0];
    else expOut = {d[30:0], 1'b0} & m[31:0];
  endfunction

  // Scan register contents after n bits of d pushed in behind the captured p
  function automatic logic [31:0] expPar(input logic [31:0] d, input logic [31:0] p, input logic [5:0] n);
    logic [63:0] w;
    w = {d, p} >> n;
    expPar = w[31:0];
  endfunction

  // Update pulses last one clk; each is seen once at the edge after it rises
  always @(posedge clk) begin
    if (rst) updCount <= 0;
    else if (scanUpdated === 1'b1) updCount <= updCount + 1;
  end

  // One command, held until taken, then a bounded wait for its answer
  task automatic runCmd(input logic ir, input logic rs, input logic [5:0] ln, input logic [31:0] d);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (cmdReady !== 1'b1) begin
      fails++;
      $display("Error at %0t: command not accepted", $time);
      end_of_test;
    end
    cmdValid = 1'b1;
    cmdIsIr = ir;
    cmdReset = rs;
    cmdLen = ln;
    cmdData = d;
    @(posedge clk);
    #1 cmdValid = 1'b0;
    while (rspValid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 4000) begin
      fails++;
      $display("Error at %0t: command timed out", $time);
      end_of_test;
    end
  endtask

  // Lets levels from the TCK side reach the clk side
  task waitSync;
    repeat (48) @(posedge clk);
    #1;
  endtask

  initial begin
    fails = 0;
    num_checks = 0;
    seed = 19;
    scanExp = 32'h0;
    rst = 1'b1;
    porRst = 1'b1;
    jtag_enable_fuse = 1'b1;
    jtag_disable_bit = 1'b0;
    cmdValid = 1'b0;
    cmdIsIr = 1'b0;
    cmdReset = 1'b0;
    cmdLen = 6'h1;
    cmdData = 32'h0;
    scanIn = 32'h0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    // Power-on reset needs running TCK edges to take effect
    runCmd(1'b0, 1'b1, 6'h1, 32'h0);
    porRst = 1'b0;
    runCmd(1'b0, 1'b1, 6'h1, 32'h0);
    waitSync;
    check(activeIns, INS_IDCODE, "instruction after reset");
    check(pullUpEn, 1'b1, "pull-ups on");
    check(portMode, 1'b0, "pins owned by tap");
    $display("Test reset done");
    for (i = 0; i < 16; i++) begin
      code = (i == 0) ? INS_IDCODE : (i == 1) ? INS_SCAN : (i == 2) ? 4'h0 : 4'($random(seed));
      len = (i < 2) ? 6'h20 : (i == 2) ? 6'h1 : 6'(($random(seed) & 31) + 1);
      dat = $random(seed);
      scanIn = $random(seed);
      updBase = updCount;
      runCmd(1'b1, 1'b0, 6'h4, {28'h0, code});
      check(rspData, {28'h0, IR_CAPTURE}, "captured instruction");
      waitSync;
      check(activeIns, code, "active instruction");
      runCmd(1'b0, 1'b0, len, dat);
      expv = expOut(code, dat, scanIn, len);
      check(rspData, expv, "data shifted out");
      if (code == INS_SCAN) scanExp = expPar(dat, scanIn, len);
      waitSync;
      check(scanOut, scanExp, "parallel output");
      check(updCount - updBase, (code == INS_SCAN) ? 1 : 0, "update pulses");
      $display("Test scan %0d code %h length %0d done", i, code, len);
    end
    runCmd(1'b1, 1'b0, 6'h4, {28'h0, INS_SCAN});
    runCmd(1'b0, 1'b1, 6'h1, 32'h0);
    waitSync;
    check(activeIns, INS_IDCODE, "five ones reset");
    runCmd(1'b1, 1'b0, 6'h4, {28'h0, INS_SCAN});
    waitSync;
    check(activeIns, INS_SCAN, "scan selected before disable");
    jtag_enable_fuse = 1'b0;
    waitSync;
    check(activeIns, INS_IDCODE, "tap reset by fuse");
    runCmd(1'b1, 1'b0, 6'h4, {28'h0, INS_SCAN});
    waitSync;
    check(activeIns, INS_IDCODE, "tap held in reset");
    check(portMode, 1'b1, "pins are port");
    check(pullUpEn, 1'b0, "pull-ups off");
    jtag_enable_fuse = 1'b1;
    jtag_disable_bit = 1'b1;
    waitSync;
    check(pullUpEn, 1'b0, "disable bit set");
    jtag_disable_bit = 1'b0;
    runCmd(1'b0, 1'b1, 6'h1, 32'h0);
    waitSync;
    check(pullUpEn, 1'b1, "enabled again");
    runCmd(1'b0, 1'b0, 6'h20, $random(seed));
    check(rspData, ID_VAL, "identity after enable");
    $display("Test enable controls done");
    end_of_test;
  end
endmodule

/* File: jtp_if.sv */
// Interface: the four TAP wires plus the TDO enable between debugger and device
`timescale 1ns/1ps
interface jtp_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdoOe;

  modport dev (
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdoOe
  );

  modport host (
    output tck,
    output tms,
    output tdi,
    input tdo,
    input tdoOe
  );
endinterface

/* File: jtp_pkg.sv */
// Package: TAP states, instruction codes and register widths shared by both ends
package jtp_pkg;

  // ********************************
  // TAP controller states
  // ********************************
  typedef enum logic [15:0] {
    TLR  = 16'h0001,
    RTI  = 16'h0002,
    SDRS = 16'h0004,
    CDR  = 16'h0008,
    SHDR = 16'h0010,
    E1DR = 16'h0020,
    PDR  = 16'h0040,
    E2DR = 16'h0080,
    UDR  = 16'h0100,
    SIRS = 16'h0200,
    CIR  = 16'h0400,
    SHIR = 16'h0800,
    E1IR = 16'h1000,
    PIR  = 16'h2000,
    E2IR = 16'h4000,
    UIR  = 16'h8000
  } jtp_state_e;

  // ********************************
  // Widths and codes
  // ********************************
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET_VAL = 4'hF;
  localparam logic [3:0] INS_IDCODE = 4'h1;
  localparam logic [3:0] INS_SCAN = 4'h2;
  localparam logic [3:0] INS_BYPASS = 4'hF;
  localparam int RESET_TMS_ONES = 5;
  localparam int TCK_DIV = 4;

  // Next state of the standard 16-state TAP machine
  function automatic jtp_state_e tapNext(input jtp_state_e s, input logic tms);
    case (s)
      TLR: tapNext = tms ? TLR : RTI;
      RTI: tapNext = tms ? SDRS : RTI;
      SDRS: tapNext = tms ? SIRS : CDR;
      CDR: tapNext = tms ? E1DR : SHDR;
      SHDR: tapNext = tms ? E1DR : SHDR;
      E1DR: tapNext = tms ? UDR : PDR;
      PDR: tapNext = tms ? E2DR : PDR;
      E2DR: tapNext = tms ? UDR : SHDR;
      UDR: tapNext = tms ? SDRS : RTI;
      SIRS: tapNext = tms ? TLR : CIR;
      CIR: tapNext = tms ? E1IR : SHIR;
      SHIR: tapNext = tms ? E1IR : SHIR;
      E1IR: tapNext = tms ? UIR : PIR;
      PIR: tapNext = tms ? E2IR : PIR;
      E2IR: tapNext = tms ? UIR : SHIR;
      UIR: tapNext = tms ? SDRS : RTI;
      default: tapNext = TLR;
    endcase
  endfunction

endpackage

/* File: jtp_tap_checker.sv */
// Checker: TAP wire behaviour seen between the two ends
`timescale 1ns/1ps
module jtp_tap_checker
  import jtp_pkg::*;
(
  // Link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdoOe,
  // Resets and enables
  input wire logic porRst,
  input wire logic jtag_enable_fuse,
  input wire logic jtag_disable_bit,
  // System clock
  input wire logic clk,
  input wire logic rst
);
  import jtp_pkg::*;

  jtp_state_e st_r;
  logic [IR_W-1:0] sh_r;
  logic [IR_W-1:0] ir_r;
  logic [1:0] enS1_r;
  logic [1:0] enS2_r;
  logic off;
  logic byp;

  // Mirrors the device's two-stage enable synchroniser so both leave reset together
  always_ff @(posedge tck) begin
    enS1_r <= {jtag_enable_fuse, jtag_disable_bit};
    enS2_r <= enS1_r;
  end
  assign off = porRst | ~enS2_r[1] | enS2_r[0];
  assign byp = (ir_r != INS_IDCODE) && (ir_r != INS_SCAN);

  // ********************************
  // Shadow of the TAP, needed to judge the wire
  // ********************************
  always_ff @(posedge tck) begin
    if (off) st_r <= TLR;
    else st_r <= tapNext(st_r, tms);
  end

  always_ff @(posedge tck) begin
    if (st_r == SHIR) sh_r <= {tdi, sh_r[IR_W-1:1]};
  end

  always_ff @(posedge tck) begin
    if (off || st_r == TLR) ir_r <= INS_IDCODE;
    else if (st_r == UIR) ir_r <= sh_r;
  end

  // ********************************
  // Assertions
  // ********************************
  a_oe_ir_shift: assert property (@(posedge tck) disable iff (off) st_r == SHIR |-> tdoOe)
    else $error("tdo not driven in instruction shift");
  a_oe_dr_shift: assert property (@(posedge tck) disable iff (off) st_r == SHDR |-> tdoOe)
    else $error("tdo not driven in data shift");
  a_oe_quiet_else: assert property (@(posedge tck) disable iff (off) st_r != SHIR && st_r != SHDR |-> !tdoOe)
    else $error("tdo driven outside a shift state");
  a_ir_capture_lsb: assert property (@(posedge tck) disable iff (off)
    st_r == SHIR && $past(st_r) == CIR |-> tdo == IR_CAPTURE[0])
    else $error("first instruction bit out is wrong");
  a_ir_capture_next: assert property (@(posedge tck) disable iff (off)
    st_r == SHIR && $past(st_r) == SHIR && $past(st_r, 2) == CIR |-> tdo == IR_CAPTURE[1])
    else $error("second instruction bit out is wrong");
  a_byp_capture_zero: assert property (@(posedge tck) disable iff (off)
    st_r == SHDR && $past(st_r) == CDR && byp |-> !tdo)
    else $error("bypass did not capture zero");
  a_byp_one_delay: assert property (@(posedge tck) disable iff (off)
    st_r == SHDR && $past(st_r) == SHDR && byp |-> tdo == $past(tdi))
    else $error("bypass path is not one stage");
  a_tdo_steady_high: assert property (@(posedge clk) disable iff (rst || off) tck && $past(tck) |-> $stable(tdo))
    else $error("tdo moved while tck high");
endmodule

/* File: jtp_tap_device.sv */
// Device end: TAP controller on the link clock with a crossing to the user clock
// Contract
// - Sixteen states, TMS sampled on TCK rise
// - Power-on reset enters Test-Logic-Reset
// - All scan paths shift LSB first
// - Host reaches Shift-IR with TMS 1,1,0,0
// - Four-bit IR, MSB shifted on exit
// - Capture-IR loads fixed value 0x01
// - Instruction latched in Update-IR
// - Instruction selects data register path
// - Host reaches Shift-DR with TMS 1,0,0
// - Host holds TMS low except last bit
// - Capture-DR loads parallel inputs, shifts out
// - Parallel output updated only in Update-DR
// - Exit and pause states do nothing
// - Update-IR may go straight to Select-DR
// - Five TMS-high clocks force Test-Logic-Reset
// - No test reset pin exists
// - Fuse unprogrammed: pins are port, TAP reset
// - Fuse set, disable clear: pull-ups, TAP on
// - Debugger monitors open-collector system reset (not built: the host has no system reset input)
// - ID, bypass, scan and programming registers (no programming register is built)
`timescale 1ns/1ps
module jtp_tap_device
  import jtp_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h1234_5677
) (
  // Link
  jtp_if.dev tap,
  // Power-on reset, in TCK domain
  input wire logic porRst,
  // Enable controls
  input wire logic jtag_enable_fuse,
  input wire logic jtag_disable_bit,
  // User side, clk domain
  input wire logic clk,
  input wire logic rst,
  input wire logic [DR_W-1:0] scanIn,
  output logic [DR_W-1:0] scanOut,
  output logic scanUpdated,
  output logic [IR_W-1:0] activeIns,
  output logic pullUpEn,
  output logic portMode
);
  import jtp_pkg::*;

  // ********************************
  // Enable and reset in TCK domain
  // ********************************
  logic [1:0] enSync1_r;
  logic [1:0] enSync2_r;
  logic tapRst;
  jtp_state_e state_r;
  logic [IR_W-1:0] irShift_r;
  logic [IR_W-1:0] ir_r;
  logic [DR_W-1:0] drShift_r;
  logic [DR_W-1:0] drOut_r;
  logic updTgl_r;
  logic tdo_r;
  logic tdoOe_r;
  logic [DR_W-1:0] capSync1_r;
  logic [DR_W-1:0] capSync2_r;
  logic [DR_W-1:0] scanOut_nxt;

  always_ff @(posedge tap.tck) begin
    enSync1_r <= {jtag_enable_fuse, jtag_disable_bit};
    enSync2_r <= enSync1_r;
  end
  // Only power-on and the disabled state reset the TAP; no TRST pin
  assign tapRst = porRst | ~enSync2_r[1] | enSync2_r[0];

  // ********************************
  // State machine
  // ********************************
  always_ff @(posedge tap.tck) begin
    if (tapRst) begin
      state_r <= TLR;
    end else begin
      // Five TMS-high clocks land in TLR from any state via the table
      state_r <= tapNext(state_r, tap.tms);
    end
  end

  // ********************************
  // Instruction register
  // ********************************
  always_ff @(posedge tap.tck) begin
    if (tapRst || state_r == TLR) begin
      irShift_r <= IR_CAPTURE;
      ir_r <= INS_IDCODE;
    end else begin
      case (state_r)
        CIR: irShift_r <= IR_CAPTURE;
        SHIR: irShift_r <= {tap.tdi, irShift_r[IR_W-1:1]};
        UIR: ir_r <= irShift_r;
        default: irShift_r <= irShift_r;
      endcase
    end
  end

  // Synchronised copy of the scan chain's parallel inputs
  // Limitation: no handshake, so the inputs must stay steady around Capture-DR
  always_ff @(posedge tap.tck) begin
    capSync1_r <= scanIn;
    capSync2_r <= capSync1_r;
  end

  // ********************************
  // Data registers
  // ********************************
  always_ff @(posedge tap.tck) begin
    if (tapRst) begin
      drShift_r <= '0;
      drOut_r <= '0;
      updTgl_r <= 1'b0;
    end else begin
      case (state_r)
        CDR: begin
          case (ir_r)
            INS_IDCODE: drShift_r <= ID_VALUE;
            INS_SCAN: drShift_r <= capSync2_r;
            default: drShift_r <= '0;
          endcase
        end
        SHDR: begin
          if (ir_r == INS_IDCODE || ir_r == INS_SCAN) begin
            drShift_r <= {tap.tdi, drShift_r[DR_W-1:1]};
          end else begin
            drShift_r[0] <= tap.tdi;
          end
        end
        UDR: begin
          if (ir_r == INS_SCAN) begin
            drOut_r <= drShift_r;
            updTgl_r <= ~updTgl_r;
          end
        end
        default: drShift_r <= drShift_r;
      endcase
    end
  end

  // TDO changes on the falling edge so the host samples a stable bit
  always_ff @(negedge tap.tck) begin
    if (tapRst) begin
      tdo_r <= 1'b0;
      tdoOe_r <= 1'b0;
    end else begin
      tdoOe_r <= (state_r == SHIR) || (state_r == SHDR);
      tdo_r <= (state_r == SHIR) ? irShift_r[0] : drShift_r[0];
    end
  end
  assign tap.tdo = tdo_r;
  assign tap.tdoOe = tdoOe_r;

  // ********************************
  // Crossing to clk domain
  // ********************************
  logic tglS1_r;
  logic tglS2_r;
  logic tglS3_r;
  logic [IR_W-1:0] insS1_r;
  logic [IR_W-1:0] insS2_r;
  logic [IR_W-1:0] insS3_r;
  logic [1:0] enS1_r;
  logic [1:0] enS2_r;

  always_ff @(posedge clk) begin
    tglS1_r <= updTgl_r;
    tglS2_r <= tglS1_r;
    insS1_r <= ir_r;
    insS2_r <= insS1_r;
    insS3_r <= insS2_r;
    enS1_r <= {jtag_enable_fuse, jtag_disable_bit};
    enS2_r <= enS1_r;
  end

  // drOut_r is stable long before the toggle arrives, so sampling it then is safe
  always_comb begin
    scanOut_nxt = scanOut;
    if (tglS2_r != tglS3_r) begin
      scanOut_nxt = drOut_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tglS3_r <= 1'b0;
      scanOut <= '0;
      scanUpdated <= 1'b0;
      activeIns <= INS_IDCODE;
      pullUpEn <= 1'b0;
      portMode <= 1'b1;
    end else begin
      tglS3_r <= tglS2_r;
      scanOut <= scanOut_nxt;
      scanUpdated <= tglS2_r != tglS3_r;
      // Code taken only when two samples agree, so a half-changed word never shows
      activeIns <= (insS2_r == insS3_r) ? insS2_r : activeIns;
      pullUpEn <= enS2_r[1] & ~enS2_r[0];
      portMode <= ~enS2_r[1] | enS2_r[0];
    end
  end
endmodule

/* File: jtp_tap_host.sv */
// Debugger end: divides clk into TCK and runs IR or DR scans
`timescale 1ns/1ps
module jtp_tap_host
  import jtp_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Command
  input wire logic cmdValid,
  input wire logic cmdIsIr,
  input wire logic cmdReset,
  input wire logic [5:0] cmdLen,
  input wire logic [DR_W-1:0] cmdData,
  output logic cmdReady,
  output logic [DR_W-1:0] rspData,
  output logic rspValid,
  // Link
  jtp_if.host tap
);
  import jtp_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_NAV = 4'b0010,
    H_SHIFT = 4'b0100,
    H_DONE = 4'b1000
  } jtp_hstate_e;

  // ********************************
  // TCK divider
  // ********************************
  logic [1:0] div_r;
  logic tck_r;
  logic rise;
  logic fall;
  assign rise = (div_r == 2'(TCK_DIV - 1)) && !tck_r;
  assign fall = (div_r == 2'(TCK_DIV - 1)) && tck_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= '0;
      tck_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'd1;
      if (div_r == 2'(TCK_DIV - 1)) begin
        tck_r <= ~tck_r;
      end
    end
  end

  // ********************************
  // Sequencer
  // ********************************
  jtp_hstate_e st_r;
  logic [7:0] tmsSeq_r;
  logic [3:0] seqLen_r;
  logic [5:0] bitCnt_r;
  logic [DR_W-1:0] sh_r;
  logic [DR_W-1:0] cap_r;
  logic [2:0] postLen_r;
  // Command fields are held here so the inputs may change once a command is taken
  logic [5:0] len_r;
  logic isRst_r;
  logic tms_r;
  logic tdi_r;
  logic tdoS1_r;
  logic tdoS2_r;

  always_ff @(posedge clk) begin
    tdoS1_r <= tap.tdo;
    tdoS2_r <= tdoS1_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= H_IDLE;
      tmsSeq_r <= '0;
      seqLen_r <= '0;
      bitCnt_r <= '0;
      sh_r <= '0;
      cap_r <= '0;
      postLen_r <= '0;
      len_r <= '0;
      isRst_r <= 1'b0;
      tms_r <= 1'b1;
      tdi_r <= 1'b0;
      cmdReady <= 1'b0;
      rspData <= '0;
      rspValid <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      cmdReady <= (st_r == H_IDLE) && !cmdValid;
      case (st_r)
        H_IDLE: begin
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            sh_r <= cmdData;
            bitCnt_r <= cmdLen;
            len_r <= cmdLen;
            isRst_r <= cmdReset;
            // Sequences are sent LSB first, one bit per TCK fall
            if (cmdReset) begin
              tmsSeq_r <= 8'b0001_1111;
              seqLen_r <= 4'd6;
            end else if (cmdIsIr) begin
              tmsSeq_r <= 8'b0000_0011;
              seqLen_r <= 4'd4;
            end else begin
              tmsSeq_r <= 8'b0000_0001;
              seqLen_r <= 4'd3;
            end
            st_r <= H_NAV;
          end
        end
        H_NAV: begin
          if (fall) begin
            tms_r <= tmsSeq_r[0];
            tmsSeq_r <= {1'b0, tmsSeq_r[7:1]};
            seqLen_r <= seqLen_r - 4'd1;
            if (seqLen_r == 4'd0) begin
              if (tmsSeq_r == 8'h00 && postLen_r == 3'd0 && !isRst_r) begin
                // First data bit must already stand at the first shift edge
                st_r <= H_SHIFT;
                tdi_r <= sh_r[0];
                tms_r <= (bitCnt_r == 6'd1);
              end else begin
                st_r <= H_DONE;
                tms_r <= 1'b0;
              end
            end
          end
        end
        H_SHIFT: begin
          if (fall) begin
            tdi_r <= sh_r[0];
            tms_r <= (bitCnt_r == 6'd1);
          end
          if (rise) begin
            cap_r <= {tdoS2_r, cap_r[DR_W-1:1]};
            sh_r <= {1'b0, sh_r[DR_W-1:1]};
            bitCnt_r <= bitCnt_r - 6'd1;
            if (bitCnt_r == 6'd1) begin
              // Exit1 -> Update -> Run-Test/Idle
              tmsSeq_r <= 8'b0000_0001;
              seqLen_r <= 4'd2;
              postLen_r <= 3'd1;
              st_r <= H_NAV;
            end
          end
        end
        default: begin
          postLen_r <= '0;
          rspData <= cap_r >> (6'(DR_W) - len_r);
          rspValid <= 1'b1;
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign tap.tck = tck_r;
  assign tap.tms = tms_r;
  assign tap.tdi = tdi_r;
endmodule
